/* rtl/weld_stepper.v */
/*
 weld stepper: weld tally, tip-dress error, ten-step linear heat/current
 ramp, calibration values, error severity map and input routing.
 assumes synchronous inputs, one weld pulse per weld, register port master.
*/
// Overview of operation
// - tally counts each delivered weld since the last stepper clear, up to 9999
// - tip-dress error raised when tally equals dress limit, default 9000
// - confirmed stepper clear forces the tally to zero
// - ten steps, each with count, heat and current; zero count means unused
// - added value rises or falls linearly per weld to full increment at step count
// - heat increment 0-99 percent added to phase shift of both welds
// - current increment 0-99.99 kA added to current of both welds
// - enabled: cc uses current only, phase uses heat only; disabled: none
// - each error has severity major, minor or none, default minor
// - hardwired: input origin local, signal source picks pi or local pin
// - origin remote 1 takes value from explicit network messages
// - signal source remote 2 uses implicit data, ignores function and origin
// - primary sensor sensitivity 1260-1540 mV/kA, default 1400
// - secondary sensor sensitivity 135-165 mV/kA, default 150
// - supply scale factor 0.80-1.20, default 1.00, held in hundredths
// - transformer turns ratio 10-255, default 50, used for current
`timescale 1ns/1ps
`include "weld_stepper_defines.vh"

module weld_stepper #(
  parameter NUM_STEPS = `WS_NUM_STEPS,
  parameter NUM_SIGS = 6
) (
  // clock and reset
  input wire i_sys_clk,
  input wire i_rst_n,
  // register port
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  // sequencer
  input wire i_weld_done,
  input wire i_clear_confirm,
  input wire i_sched_cc,
  input wire [6:0] i_base_heat,
  input wire [13:0] i_base_cur,
  input wire [4:0] i_err_code,
  output reg [7:0] o_heat_w1,
  output reg [7:0] o_heat_w2,
  output reg [14:0] o_cur_w1,
  output reg [14:0] o_cur_w2,
  output reg [21:0] o_prim_cur,
  output reg [1:0] o_err_severity,
  output reg o_tip_dress_err,
  // inputs to route
  input wire [NUM_SIGS-1:0] i_local_pin,
  input wire [NUM_SIGS-1:0] i_term_val,
  input wire [NUM_SIGS-1:0] i_explicit_val,
  input wire [NUM_SIGS-1:0] i_implicit_val,
  output reg [NUM_SIGS-1:0] o_routed
);
  localparam ST_IDLE = 2'b01;
  localparam ST_RAMP = 2'b10;

  reg [1:0] state_r;
  reg [13:0] tally_r;
  reg [13:0] dress_r;
  reg en_r;
  reg [10:0] pri_sens_r;
  reg [7:0] sec_sens_r;
  reg [6:0] scale_r;
  reg [7:0] turns_r;
  reg [2*NUM_SIGS-1:0] origin_r;
  reg [2*NUM_SIGS-1:0] sigsrc_r;
  reg [2*`WS_NUM_ERRS-1:0] sev_r;
  reg [13:0] step_cnt_r [0:NUM_STEPS-1];
  reg [6:0] step_heat_r [0:NUM_STEPS-1];
  reg [13:0] step_cur_r [0:NUM_STEPS-1];
  reg [3:0] step_idx_r;
  reg [13:0] in_step_r;
  reg [6:0] heat_add_r;
  reg [13:0] cur_add_r;

  wire [NUM_SIGS-1:0] routed;
  wire clear_req;
  wire [3:0] reg_idx;
  wire [1:0] reg_fld;
  reg [13:0] tally_nxt;
  reg [6:0] prev_heat;
  reg [13:0] prev_cur;
  reg [6:0] heat_diff;
  reg [13:0] cur_diff;
  reg [27:0] heat_prod;
  reg [27:0] cur_prod;
  reg [27:0] heat_quo;
  reg [27:0] cur_quo;
  reg [6:0] heat_lin;
  reg [13:0] cur_lin;
  wire [13:0] in_nxt;
  wire [22:0] prim_prod;
  integer k;

  assign reg_idx = i_addr[5:2];
  assign reg_fld = i_addr[7:6] == 2'b10 ? 2'd0 : (i_addr[7:6] == 2'b11 ? 2'd1 : 2'd3);
  assign clear_req = i_clear_confirm | (i_wr && i_addr == `WS_ADDR_CTRL && i_wdata[`WS_CTRL_CLR_BIT]);
  assign in_nxt = in_step_r + 14'd1;
  assign prim_prod = {8'd0, o_cur_w2} * {15'd0, turns_r};

  genvar g;
  generate
    for (g = 0; g < NUM_SIGS; g = g + 1) begin : g_route
      ws_input_route u_route (
        .i_pi_origin(origin_r[2*g+1:2*g]),
        .i_sig_remote2(sigsrc_r[2*g+1:2*g] == `WS_SRC_REMOTE2),
        .i_use_pi(sigsrc_r[2*g+1:2*g] != `WS_SRC_REMOTE1),
        .i_local_pin(i_local_pin[g]),
        .i_term_val(i_term_val[g]),
        .i_explicit_val(i_explicit_val[g]),
        .i_implicit_val(i_implicit_val[g]),
        .o_routed(routed[g])
      );
    end
  endgenerate

  // tally next value; clear wins over a weld in the same cycle, since it is a reset
  always @* begin
    tally_nxt = tally_r;
    if (clear_req) begin
      tally_nxt = 14'd0;
    end else if (i_weld_done && tally_r != `WS_TALLY_MAX) begin
      tally_nxt = tally_r + 14'd1;
    end
  end

  // linear ramp from previous step level toward this step's full increment
  always @* begin
    if (step_idx_r == 4'd0) begin
      prev_heat = 7'd0;
      prev_cur = 14'd0;
    end else begin
      prev_heat = step_heat_r[step_idx_r - 4'd1];
      prev_cur = step_cur_r[step_idx_r - 4'd1];
    end
    // magnitude of the change; a step may also lower the level
    heat_diff = (step_heat_r[step_idx_r] >= prev_heat) ?
                step_heat_r[step_idx_r] - prev_heat : prev_heat - step_heat_r[step_idx_r];
    cur_diff = (step_cur_r[step_idx_r] >= prev_cur) ?
               step_cur_r[step_idx_r] - prev_cur : prev_cur - step_cur_r[step_idx_r];
    heat_prod = {21'd0, heat_diff} * {14'd0, in_nxt};
    cur_prod = {14'd0, cur_diff} * {14'd0, in_nxt};
    heat_quo = 28'd0;
    cur_quo = 28'd0;
    // combinational divide: area traded for a same-cycle level per weld
    if (step_cnt_r[step_idx_r] != 14'd0) begin
      heat_quo = heat_prod / {14'd0, step_cnt_r[step_idx_r]};
      cur_quo = cur_prod / {14'd0, step_cnt_r[step_idx_r]};
    end
    // used only while in_nxt is below the count, so the quotient fits the change
    if (step_heat_r[step_idx_r] >= prev_heat) begin
      heat_lin = prev_heat + heat_quo[6:0];
    end else begin
      heat_lin = prev_heat - heat_quo[6:0];
    end
    if (step_cur_r[step_idx_r] >= prev_cur) begin
      cur_lin = prev_cur + cur_quo[13:0];
    end else begin
      cur_lin = prev_cur - cur_quo[13:0];
    end
  end

  // step tracking: advance when the in-step count hits the step count
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
      step_idx_r <= 4'd0;
      in_step_r <= 14'd0;
      heat_add_r <= 7'd0;
      cur_add_r <= 14'd0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (step_cnt_r[0] != 14'd0) begin
            state_r <= ST_RAMP;
          end
        end
        ST_RAMP: begin
          if (clear_req) begin
            step_idx_r <= 4'd0;
            in_step_r <= 14'd0;
            heat_add_r <= 7'd0;
            cur_add_r <= 14'd0;
          end else if (i_weld_done) begin
            if (in_nxt >= step_cnt_r[step_idx_r]) begin
              heat_add_r <= step_heat_r[step_idx_r];
              cur_add_r <= step_cur_r[step_idx_r];
              // a zero-count step ends the list; last level is held
              if (step_idx_r != NUM_STEPS - 1 && step_cnt_r[step_idx_r + 4'd1] != 14'd0) begin
                step_idx_r <= step_idx_r + 4'd1;
                in_step_r <= 14'd0;
              end else begin
                in_step_r <= step_cnt_r[step_idx_r];
              end
            end else begin
              in_step_r <= in_nxt;
              heat_add_r <= heat_lin;
              cur_add_r <= cur_lin;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // registers and tally
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tally_r <= 14'd0;
      dress_r <= `WS_DRESS_DFLT;
      en_r <= 1'b0;
      pri_sens_r <= `WS_PRI_SENS_DFLT;
      sec_sens_r <= `WS_SEC_SENS_DFLT;
      scale_r <= `WS_SCALE_DFLT;
      turns_r <= `WS_TURNS_DFLT;
      origin_r <= {2*NUM_SIGS{1'b0}};
      sigsrc_r <= {2*NUM_SIGS{1'b0}};
      for (k = 0; k < `WS_NUM_ERRS; k = k + 1) begin
        sev_r[2*k +: 2] <= `WS_SEV_MINOR;
      end
      for (k = 0; k < NUM_STEPS; k = k + 1) begin
        step_cnt_r[k] <= 14'd0;
        step_heat_r[k] <= 7'd0;
        step_cur_r[k] <= 14'd0;
      end
    end else begin
      tally_r <= tally_nxt;
      if (i_wr) begin
        case (i_addr)
          `WS_ADDR_CTRL: en_r <= i_wdata[`WS_CTRL_EN_BIT];
          `WS_ADDR_DRESS: if (i_wdata[13:0] <= `WS_TALLY_MAX) dress_r <= i_wdata[13:0];
          // out-of-range values are ignored, old setting kept
          `WS_ADDR_PRI_SENS: if (i_wdata[10:0] >= `WS_PRI_SENS_MIN &&
                                 i_wdata[10:0] <= `WS_PRI_SENS_MAX &&
                                 i_wdata[31:11] == 21'd0) pri_sens_r <= i_wdata[10:0];
          `WS_ADDR_SEC_SENS: if (i_wdata[7:0] >= `WS_SEC_SENS_MIN &&
                                 i_wdata[7:0] <= `WS_SEC_SENS_MAX &&
                                 i_wdata[31:8] == 24'd0) sec_sens_r <= i_wdata[7:0];
          `WS_ADDR_SCALE: if (i_wdata[6:0] >= `WS_SCALE_MIN && i_wdata[6:0] <= `WS_SCALE_MAX &&
                              i_wdata[31:7] == 25'd0) scale_r <= i_wdata[6:0];
          `WS_ADDR_TURNS: if (i_wdata[7:0] >= `WS_TURNS_MIN &&
                              i_wdata[31:8] == 24'd0) turns_r <= i_wdata[7:0];
          `WS_ADDR_PI_ORIGIN: origin_r <= i_wdata[2*NUM_SIGS-1:0];
          `WS_ADDR_SIG_SRC: sigsrc_r <= i_wdata[2*NUM_SIGS-1:0];
          default: begin
            if (i_addr[7:6] == 2'b01) begin
              sev_r <= sev_r;
              for (k = 0; k < 16; k = k + 1) begin
                if (i_addr[5:2] < 4'd2 && i_wdata[2*k +: 2] != 2'd3) begin
                  sev_r[32*i_addr[2] + 2*k +: 2] <= i_wdata[2*k +: 2];
                end
              end
            end else if (i_addr[7] && reg_idx < NUM_STEPS) begin
              if (i_addr[7:6] == 2'b10 && i_wdata[13:0] <= `WS_TALLY_MAX) begin
                step_cnt_r[reg_idx] <= i_wdata[13:0];
              end else if (i_addr[7:6] == 2'b11) begin
                if (i_wdata[6:0] <= `WS_HEAT_MAX) step_heat_r[reg_idx] <= i_wdata[6:0];
                if (i_wdata[29:16] <= `WS_CUR_MAX) step_cur_r[reg_idx] <= i_wdata[29:16];
              end
            end
          end
        endcase
      end
    end
  end

  // outputs: increments applied per schedule mode
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_heat_w1 <= 8'd0;
      o_heat_w2 <= 8'd0;
      o_cur_w1 <= 15'd0;
      o_cur_w2 <= 15'd0;
      o_prim_cur <= 22'd0;
      o_err_severity <= `WS_SEV_MINOR;
      o_tip_dress_err <= 1'b0;
      o_routed <= {NUM_SIGS{1'b0}};
      o_rdata <= 32'h0000_0000;
    end else begin
      o_heat_w1 <= {1'b0, i_base_heat} + ((en_r && !i_sched_cc) ? {1'b0, heat_add_r} : 8'd0);
      o_heat_w2 <= {1'b0, i_base_heat} + ((en_r && !i_sched_cc) ? {1'b0, heat_add_r} : 8'd0);
      o_cur_w1 <= {1'b0, i_base_cur} + ((en_r && i_sched_cc) ? {1'b0, cur_add_r} : 15'd0);
      o_cur_w2 <= {1'b0, i_base_cur} + ((en_r && i_sched_cc) ? {1'b0, cur_add_r} : 15'd0);
      // wraps above 22 bits only at extreme current and turns together
      o_prim_cur <= prim_prod[21:0];
      o_err_severity <= sev_r[2*i_err_code +: 2];
      o_tip_dress_err <= (tally_r == dress_r);
      o_routed <= routed;
      o_rdata <= 32'h0000_0000;
      if (i_rd) begin
        case (i_addr)
          `WS_ADDR_CTRL: o_rdata <= {31'd0, en_r};
          `WS_ADDR_TALLY: o_rdata <= {18'd0, tally_r};
          `WS_ADDR_DRESS: o_rdata <= {18'd0, dress_r};
          `WS_ADDR_PRI_SENS: o_rdata <= {21'd0, pri_sens_r};
          `WS_ADDR_SEC_SENS: o_rdata <= {24'd0, sec_sens_r};
          `WS_ADDR_SCALE: o_rdata <= {25'd0, scale_r};
          `WS_ADDR_TURNS: o_rdata <= {24'd0, turns_r};
          `WS_ADDR_PI_ORIGIN: o_rdata <= {{(32-2*NUM_SIGS){1'b0}}, origin_r};
          `WS_ADDR_SIG_SRC: o_rdata <= {{(32-2*NUM_SIGS){1'b0}}, sigsrc_r};
          `WS_ADDR_STATUS: o_rdata <= {6'd0, cur_add_r, heat_add_r, step_idx_r, o_tip_dress_err};
          default: begin
            if (i_addr[7:6] == 2'b01 && i_addr[5:3] == 3'd0) begin
              o_rdata <= sev_r[32*i_addr[2] +: 32];
            end else if (i_addr[7] && reg_idx < NUM_STEPS) begin
              if (reg_fld == 2'd0) o_rdata <= {18'd0, step_cnt_r[reg_idx]};
              else o_rdata <= {2'd0, step_cur_r[reg_idx], 9'd0, step_heat_r[reg_idx]};
            end
          end
        endcase
      end
    end
  end
endmodule // weld_stepper

/* include/weld_stepper_defines.vh */
/*
 constants for the weld stepper and input routing block: register offsets,
 reset values, field positions and ranges. included by the rtl files.
*/
`ifndef WELD_STEPPER_DEFINES_VH
`define WELD_STEPPER_DEFINES_VH

`define WS_TALLY_MAX 14'd9999
`define WS_DRESS_DFLT 14'd9000
`define WS_NUM_STEPS 10
`define WS_HEAT_MAX 7'd99
`define WS_CUR_MAX 14'd9999
`define WS_PRI_SENS_MIN 11'd1260
`define WS_PRI_SENS_MAX 11'd1540
`define WS_PRI_SENS_DFLT 11'd1400
`define WS_SEC_SENS_MIN 8'd135
`define WS_SEC_SENS_MAX 8'd165
`define WS_SEC_SENS_DFLT 8'd150
`define WS_SCALE_MIN 7'd80
`define WS_SCALE_MAX 7'd120
`define WS_SCALE_DFLT 7'd100
`define WS_TURNS_MIN 8'd10
`define WS_TURNS_MAX 8'd255
`define WS_TURNS_DFLT 8'd50
`define WS_NUM_ERRS 32
`define WS_SEV_NONE 2'd0
`define WS_SEV_MINOR 2'd1
`define WS_SEV_MAJOR 2'd2
`define WS_TIP_DRESS_ERR 5'd31
`define WS_SRC_LOCAL 2'd0
`define WS_SRC_REMOTE1 2'd1
`define WS_SRC_REMOTE2 2'd2

`define WS_ADDR_CTRL 8'h00
`define WS_ADDR_TALLY 8'h04
`define WS_ADDR_DRESS 8'h08
`define WS_ADDR_PRI_SENS 8'h0c
`define WS_ADDR_SEC_SENS 8'h10
`define WS_ADDR_SCALE 8'h14
`define WS_ADDR_TURNS 8'h18
`define WS_ADDR_PI_ORIGIN 8'h1c
`define WS_ADDR_SIG_SRC 8'h20
`define WS_ADDR_STATUS 8'h24
`define WS_ADDR_SEV_BASE 8'h40
`define WS_ADDR_STEP_BASE 8'h80

`define WS_CTRL_EN_BIT 0
`define WS_CTRL_CLR_BIT 1
`define WS_STAT_DRESS_BIT 0
`define WS_STEP_CNT_OFF 2'd0
`define WS_STEP_HEAT_OFF 2'd1
`define WS_STEP_CUR_OFF 2'd2

`endif

/* rtl/ws_input_route.v */
/*
 one routed input: picks local terminal, explicit remote value or implicit
 network data. assumes all inputs synchronous to the system clock.
*/
`timescale 1ns/1ps
`include "weld_stepper_defines.vh"

module ws_input_route (
  // selections
  input wire [1:0] i_pi_origin,
  input wire i_sig_remote2,
  input wire i_use_pi,
  // sources
  input wire i_local_pin,
  input wire i_term_val,
  input wire i_explicit_val,
  input wire i_implicit_val,
  // result
  output wire o_routed
);
  wire pi_val;
  // pi value from terminal or explicit message
  assign pi_val = (i_pi_origin == `WS_SRC_REMOTE1) ? i_explicit_val : i_term_val;
  // implicit data overrides function and origin
  assign o_routed = i_sig_remote2 ? i_implicit_val :
                    (i_use_pi ? pi_val : i_local_pin);
endmodule // ws_input_route

/* verif/weld_stepper_asserts.sv */
/*
 checker for weld_stepper, bound from tb_top.
 assumes one-cycle output lag and a shadow of enable and turns writes.
*/
`timescale 1ns/1ps
module weld_stepper_asserts (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_weld_done,
  input wire i_clear_confirm,
  input wire i_sched_cc,
  input wire [6:0] i_base_heat,
  input wire [13:0] i_base_cur,
  input wire [7:0] o_heat_w1,
  input wire [7:0] o_heat_w2,
  input wire [14:0] o_cur_w1,
  input wire [14:0] o_cur_w2,
  input wire [21:0] o_prim_cur,
  input wire [1:0] o_err_severity,
  input wire o_tip_dress_err
);
  reg en_r;
  reg [7:0] turns_r;
  reg [1:0] up_r;
  // checks start a few edges after reset, once outputs carry live values
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      up_r <= 2'd0;
    end else if (up_r != 2'd3) begin
      up_r <= up_r + 2'd1;
    end
  end
  wire cause = i_weld_done | i_clear_confirm | i_wr;
  // shadow registers, same write edge as the block
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_r <= 1'b0;
      turns_r <= 8'h32;
    end else if (i_wr && i_addr == 8'h00) begin
      en_r <= i_wdata[0];
    end else if (i_wr && i_addr == 8'h18 && i_wdata >= 32'h0a && i_wdata <= 32'hff) begin
      turns_r <= i_wdata[7:0];
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n || up_r != 2'd3);
  property p_err_cause; $rose(o_tip_dress_err) |-> $past(cause) || $past(cause, 2); endproperty
  a_err_cause: assert property (p_err_cause) else $error("dress flag rose alone");
  property p_off_heat; !en_r |=> o_heat_w1 == {1'b0, $past(i_base_heat)}; endproperty
  a_off_heat: assert property (p_off_heat) else $error("heat added while off");
  property p_off_cur; !en_r |=> o_cur_w1 == {1'b0, $past(i_base_cur)}; endproperty
  a_off_cur: assert property (p_off_cur) else $error("current added while off");
  property p_cc_heat; en_r && i_sched_cc |=> o_heat_w1 == {1'b0, $past(i_base_heat)}; endproperty
  a_cc_heat: assert property (p_cc_heat) else $error("heat added in cc");
  property p_ps_cur; en_r && !i_sched_cc |=> o_cur_w1 == {1'b0, $past(i_base_cur)}; endproperty
  a_ps_cur: assert property (p_ps_cur) else $error("current added in phase");
  property p_both; o_heat_w1 == o_heat_w2 && o_cur_w1 == o_cur_w2; endproperty
  a_both: assert property (p_both) else $error("weld intervals differ");
  property p_prim; o_prim_cur == $past(o_cur_w2) * $past(turns_r); endproperty
  a_prim: assert property (p_prim) else $error("primary current wrong");
  property p_sev; o_err_severity != 2'h3; endproperty
  a_sev: assert property (p_sev) else $error("bad severity code");
  c_err: cover property ($rose(o_tip_dress_err));
  c_ps: cover property (en_r && !i_sched_cc && i_weld_done);
  c_cc: cover property (en_r && i_sched_cc && i_weld_done);
endmodule // weld_stepper_asserts

/* verif/weld_partner_model.sv */
/*
 weld sequencer and network partner: weld pulses and remote input values.
 assumes the bench calls fire from its own sequence.
*/
`timescale 1ns/1ps
module weld_partner_model (
  // clock
  input wire i_sys_clk,
  // toward the block
  output reg o_weld_done,
  output reg [5:0] o_explicit_val,
  output reg [5:0] o_implicit_val
);
  initial begin
    o_weld_done = 1'b0;
    o_explicit_val = 6'h15;
    o_implicit_val = 6'h2a;
  end
  // gap 0 holds the pulse high: back-to-back welds
  task automatic fire(input int n, input int gap);
    for (int k = 0; k < n; k++) begin
      @(posedge i_sys_clk);
      o_weld_done <= 1'b1;
      if (gap > 0) begin
        @(posedge i_sys_clk);
        o_weld_done <= 1'b0;
        repeat (gap - 1) @(posedge i_sys_clk);
      end
    end
    @(posedge i_sys_clk);
    o_weld_done <= 1'b0;
  endtask
endmodule // weld_partner_model

/* verif/tb_top.sv */
/*
 testbench for weld_stepper: register tasks and directed sequences.
 assumes the partner model for welds and network values.
*/
`timescale 1ns/1ps
module tb_top;
  reg i_sys_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  reg i_clear_confirm = 1'b0, i_sched_cc = 1'b0;
  reg [7:0] i_addr = 8'h00;
  reg [31:0] i_wdata = 32'h0;
  reg [6:0] i_base_heat = 7'h0a;
  reg [13:0] i_base_cur = 14'h3e8;
  reg [4:0] i_err_code = 5'h00;
  reg [5:0] i_local_pin = 6'h33, i_term_val = 6'h0f;
  wire weld_done, o_tip_dress_err;
  wire [5:0] expl_val, impl_val, o_routed;
  wire [31:0] o_rdata;
  wire [7:0] o_heat_w1, o_heat_w2;
  wire [14:0] o_cur_w1, o_cur_w2;
  wire [21:0] o_prim_cur;
  wire [1:0] o_err_severity;
  int error_cnt = 0, checks_done = 0, n;
  logic [7:0] ra [7] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h40, 8'h44};
  logic [31:0] rv [7] = '{32'h2328, 32'h578, 32'h96, 32'h64, 32'h32, 32'h55555555, 32'h55555555};
  logic [31:0] lo [4] = '{32'h4ec, 32'h87, 32'h50, 32'h0a};
  logic [31:0] hi [4] = '{32'h604, 32'ha5, 32'h78, 32'hff};
  always #50 i_sys_clk = ~i_sys_clk;
  weld_partner_model i_weld_partner_model (.i_sys_clk(i_sys_clk), .o_weld_done(weld_done),
    .o_explicit_val(expl_val), .o_implicit_val(impl_val));
  weld_stepper #(.NUM_SIGS(6)) i_weld_stepper (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_weld_done(weld_done), .i_clear_confirm(i_clear_confirm), .i_sched_cc(i_sched_cc),
    .i_base_heat(i_base_heat), .i_base_cur(i_base_cur), .i_err_code(i_err_code),
    .o_heat_w1(o_heat_w1), .o_heat_w2(o_heat_w2), .o_cur_w1(o_cur_w1), .o_cur_w2(o_cur_w2),
    .o_prim_cur(o_prim_cur), .o_err_severity(o_err_severity),
    .o_tip_dress_err(o_tip_dress_err), .i_local_pin(i_local_pin), .i_term_val(i_term_val),
    .i_explicit_val(expl_val), .i_implicit_val(impl_val), .o_routed(o_routed));
  task chk(input [31:0] got, input [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task rd(input [7:0] a, input [31:0] e);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  task settle;
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 7; k++) rd(ra[k], rv[k]);
    rd(8'h30, 32'h0);
    for (int k = 0; k < 4; k++) begin
      wr(ra[k+1], lo[k] - 32'h1);
      wr(ra[k+1], hi[k] + 32'h1);
      rd(ra[k+1], rv[k+1]);
      wr(ra[k+1], lo[k]);
      rd(ra[k+1], lo[k]);
      wr(ra[k+1], hi[k]);
      rd(ra[k+1], hi[k]);
    end
    wr(8'h08, 32'h3);
    i_weld_partner_model.fire(3, 1);
    settle;
    chk(o_tip_dress_err, 32'h1);
    rd(8'h04, 32'h3);
    i_weld_partner_model.fire(1, 0);
    settle;
    chk(o_tip_dress_err, 32'h0);
    @(posedge i_sys_clk);
    i_clear_confirm <= 1'b1;
    @(posedge i_sys_clk);
    i_clear_confirm <= 1'b0;
    rd(8'h04, 32'h0);
    wr(8'h08, 32'h270f);
    i_weld_partner_model.fire(10001, 0);
    settle;
    rd(8'h04, 32'h270f);
    chk(o_tip_dress_err, 32'h1);
    // two steps, third unused, so the ramp stops at step two
    wr(8'h80, 32'h4);
    wr(8'hc0, 32'h01900008);
    wr(8'h84, 32'h2);
    wr(8'hc4, 32'h0258000c);
    wr(8'h00, 32'h3);
    rd(8'h04, 32'h0);
    for (int k = 0; k < 8; k++) begin
      n = (k < 6) ? k : 6;
      @(posedge i_sys_clk);
      i_sched_cc <= 1'b0;
      settle;
      chk(o_heat_w1, 32'h0a + 32'h2 * n);
      @(posedge i_sys_clk);
      i_sched_cc <= 1'b1;
      settle;
      chk(o_cur_w1, 32'h3e8 + 32'h64 * n);
      i_weld_partner_model.fire(1, 0);
    end
    settle;
    // 16.00 kA at the turns ratio of 255 left by the range scenario
    chk(o_prim_cur, 32'h639c0);
    chk(o_routed, 32'h0f);
    wr(8'h20, 32'h555);
    settle;
    chk(o_routed, 32'h33);
    wr(8'h20, 32'h0);
    wr(8'h1c, 32'h555);
    settle;
    chk(o_routed, 32'h15);
    wr(8'h20, 32'haaa);
    settle;
    chk(o_routed, 32'h2a);
    wr(8'h40, 32'h55555578);
    rd(8'h40, 32'h55555558);
    for (int k = 0; k < 4; k++) begin
      @(posedge i_sys_clk);
      i_err_code <= (k == 3) ? 5'h1f : k[4:0];
      settle;
      chk(o_err_severity, (k == 1) ? 32'h2 : (k == 0) ? 32'h0 : 32'h1);
    end
    wrap_up;
  end
  initial begin
    repeat (40000) @(posedge i_sys_clk);
    error_cnt++;
    wrap_up;
  end
endmodule // tb_top
bind weld_stepper weld_stepper_asserts i_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_weld_done(i_weld_done),
  .i_clear_confirm(i_clear_confirm), .i_sched_cc(i_sched_cc), .i_base_heat(i_base_heat),
  .i_base_cur(i_base_cur), .o_heat_w1(o_heat_w1), .o_heat_w2(o_heat_w2), .o_cur_w1(o_cur_w1),
  .o_cur_w2(o_cur_w2), .o_prim_cur(o_prim_cur), .o_err_severity(o_err_severity),
  .o_tip_dress_err(o_tip_dress_err));
